// >>> protect_fetch_consts.svh
// offsets, field positions, reset values and timing counts for the protect word fetch
`ifndef PROTECT_FETCH_CONSTS_SVH
`define PROTECT_FETCH_CONSTS_SVH

// address gate layout
`define ADDR_W         15
`define VOL_W          6
`define VOL_HI         14
`define VOL_LO         9
`define PSW_BLOCK_BIT  6
`define VOL_RESET      6'h00

// protect status word
`define PSW_W          16
`define PSW_RESET      16'h0000

// register bus byte offsets
`define OFS_CTRL       5'h00
`define OFS_STATUS     5'h04
`define OFS_PROTECT    5'h08
`define OFS_FETCHES    5'h0c

// field positions
`define CTRL_FORCE_BIT   0
`define STAT_BUSY_BIT    8
`define STAT_TRAP_BIT    9
`define STAT_FORCE_BIT   10

// timing: one word time of hold after the status word is loaded
`define CLK_PERIOD_PS  5000
`define WORD_TIME_NS   1000
`define WORD_CYCLES    ((`WORD_TIME_NS * 1000 + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
`define CNT_W          8

`endif

// >>> protect_fetch_pkg.sv
// types shared by the protect word fetch modules
`include "protect_fetch_consts.svh"

package protect_fetch_pkg;

    typedef logic [`VOL_W-1:0] vol_t;
    typedef logic [`PSW_W-1:0] psw_t;

    typedef enum logic [2:0] {
        ST_IDLE     = 3'b000,
        ST_WAIT_REL = 3'b001,
        ST_FETCH    = 3'b010,
        ST_XFER     = 3'b011,
        ST_HOLD     = 3'b100
    } fetch_state_e;

    typedef struct packed {
        vol_t volume;
    } vol_state_s;

    typedef struct packed {
        fetch_state_e     st;
        logic [`CNT_W-1:0] cnt;
        psw_t             membuf;
        psw_t             protect;
        logic             force_pend;
        logic             trap_prev;
        logic             retry_flag;
        logic             ack;
        logic [31:0]      rdata;
        logic [15:0]      fetches;
    } fetch_state_s;

endpackage

// >>> volume_if.sv
// volume register carrier between the fetch sequencer and the volume store
`timescale 1ns/1ps

interface volume_if;
    import protect_fetch_pkg::*;

    logic load;
    vol_t new_vol;
    vol_t high_bits;
    vol_t volume;
    logic differ;

    modport store (input load, input new_vol, input high_bits, output volume, output differ);
    modport user  (output load, output new_vol, output high_bits, input volume, input differ);
endinterface

// >>> volume_store.sv
// six-bit volume register and block compare
`timescale 1ns/1ps
`include "protect_fetch_consts.svh"

module volume_store
    import protect_fetch_pkg::*;
(
    // clock and reset
    input  wire logic clk,
    input  wire logic srst,
    // carrier
    volume_if.store   vif
);

    vol_state_s s_q;
    vol_state_s s_d;

    always_comb begin
        s_d = s_q;
        if (vif.load) begin
            s_d.volume = vif.new_vol; // [R8]
        end
        // no load means the held word stays valid for this block [R12]
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            s_q <= '{volume: `VOL_RESET};
        end else begin
            s_q <= s_d; // [R1]
        end
    end

    assign vif.volume = s_q.volume;
    assign vif.differ = (vif.high_bits != s_q.volume); // [R2]

    a_volume_load: assert property (@(posedge clk) disable iff (srst) // [R8]
        vif.load |=> s_q.volume == $past(vif.new_vol))
        else $error("volume not taken from address gate");

    a_volume_keep: assert property (@(posedge clk) disable iff (srst) // [R12]
        !vif.load |=> $stable(s_q.volume))
        else $error("volume changed without a load");

endmodule

// >>> protect_fetch.sv
// protect status word fetch sequencer with avalon register slave
//
// Contract
// R1: a six-bit volume register names the 512-word block of the held protect word
// R2: upper address bits 14..9 are compared with volume on P or I addressing
// R3: protection and volume handling act only while trapping mode is set
// R4: state-1 access raises difference unless interrupt, trap, prior difference, execute-indirect object, quasi
// R5: I-register access outside state 1 raises difference unless quasi relative, interrupt, trap
// R6: a difference is forced right after trapping mode becomes set
// R7: during a difference the arithmetic core is inhibited and sequence state held
// R8: on memory release during a difference, address bits 14..9 load the volume
// R9: memory then addressed with volume on bits 5..0 and bit 6 high
// R10: fetched word goes to buffer register, then through adder into protect register
// R11: after the load, hold one more word time, then retry the stalled operation
// R12: without a difference the volume is kept, so same-block accesses need no fetch
//
// Added by the designer: the address map and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`include "protect_fetch_consts.svh"

module protect_fetch
    import protect_fetch_pkg::*;
#(
    parameter int HOLD_CYCLES = `WORD_CYCLES
)(
    // clock and reset
    input  wire logic              clk,
    input  wire logic              srst,
    // avalon-mm register slave
    input  wire logic [4:0]        avs_address,
    input  wire logic              avs_read,
    input  wire logic              avs_write,
    input  wire logic [31:0]       avs_writedata,
    output logic      [31:0]       avs_readdata,
    output logic                   avs_waitrequest,
    // processor address gates and sequencing
    input  wire logic              mem_access,
    input  wire logic [`ADDR_W-1:0] address_gate,
    input  wire logic              addr_from_p,
    input  wire logic              addr_from_i,
    input  wire logic              state_one,
    input  wire logic              auto_program_interrupt,
    input  wire logic              trap_error,
    input  wire logic              execute_indirect_instr,
    input  wire logic              in_quasi,
    input  wire logic              relative_addr,
    input  wire logic              trapping_mode_ff,
    // stall and retry
    output logic                   volume_difference,
    output logic                   arithmetic_core_inhibit,
    output logic                   sequence_state_hold_high,
    output logic                   sequence_state_hold_low,
    output logic                   retry_pulse,
    // core memory
    output logic [`ADDR_W-1:0]     mem_addr,
    output logic                   mem_read_req,
    input  wire logic              mem_release,
    input  wire logic [`PSW_W-1:0] mem_rdata,
    // protect status register
    output logic [`PSW_W-1:0]      protect_word,
    output logic                   load_protect_reg
);

    if (HOLD_CYCLES < 1 || HOLD_CYCLES > (1 << `CNT_W) - 1) begin : g_bad_hold
        $error("HOLD_CYCLES out of counter range");
    end

    localparam logic [`CNT_W-1:0] HOLD_LAST = `CNT_W'(HOLD_CYCLES - 1);

    fetch_state_s s_q;
    fetch_state_s s_d;

    volume_if vif ();

    volume_store u_volume (
        .clk  (clk),
        .srst (srst),
        .vif  (vif)
    );

    logic qual_state1;
    logic qual_ireg;
    logic start;
    logic trap_rise;
    logic bus_req;
    logic bus_done;
    logic sw_force;

    assign trap_rise = trapping_mode_ff && !s_q.trap_prev;

    // state-1 path, blocked by the listed sources [R4]
    assign qual_state1 = state_one && (addr_from_p || addr_from_i) && !auto_program_interrupt
                         && !trap_error && !s_q.retry_flag && !execute_indirect_instr && !in_quasi;
    // I-register path outside state 1 [R5]
    assign qual_ireg = addr_from_i && !state_one && !(relative_addr && in_quasi)
                       && !auto_program_interrupt && !trap_error;

    // only in trapping mode; forced difference ignores the compare [R3] [R6]
    assign start = (s_q.st == ST_IDLE) && mem_access && trapping_mode_ff
                   && ((s_q.force_pend && (addr_from_p || addr_from_i))
                       || ((qual_state1 || qual_ireg) && vif.differ)); // [R2]

    assign bus_req  = avs_read || avs_write;
    assign bus_done = bus_req && s_q.ack;
    assign sw_force = bus_done && avs_write && (avs_address == `OFS_CTRL)
                      && avs_writedata[`CTRL_FORCE_BIT];

    assign vif.high_bits = address_gate[`VOL_HI:`VOL_LO];
    assign vif.new_vol   = address_gate[`VOL_HI:`VOL_LO];
    assign vif.load      = (s_q.st == ST_WAIT_REL) && mem_release; // [R8]

    always_comb begin
        s_d = s_q;
        s_d.trap_prev = trapping_mode_ff;
        s_d.ack = bus_req && !s_q.ack;
        // status read captured one edge before the answer
        case (avs_address)
            `OFS_CTRL:    s_d.rdata = 32'h0000_0000;
            `OFS_STATUS:  s_d.rdata = {21'h0, s_q.force_pend, trapping_mode_ff,
                                       s_q.st != ST_IDLE, 2'h0, vif.volume};
            `OFS_PROTECT: s_d.rdata = {16'h0, s_q.protect};
            `OFS_FETCHES: s_d.rdata = {16'h0, s_q.fetches};
            default:      s_d.rdata = 32'h0000_0000;
        endcase
        if (mem_access && s_q.st == ST_IDLE) begin
            s_d.retry_flag = 1'b0;
        end
        case (s_q.st)
            ST_IDLE: begin
                if (start) begin
                    s_d.st = ST_WAIT_REL;
                end
            end
            ST_WAIT_REL: begin
                if (mem_release) begin
                    s_d.st = ST_FETCH;
                end
            end
            ST_FETCH: begin
                if (mem_release) begin
                    s_d.membuf = mem_rdata; // [R10]
                    s_d.st = ST_XFER;
                end
            end
            ST_XFER: begin
                s_d.protect = s_q.membuf; // [R10]
                s_d.cnt = HOLD_LAST;
                s_d.fetches = s_q.fetches + 16'h0001;
                s_d.force_pend = 1'b0;
                s_d.st = ST_HOLD;
            end
            ST_HOLD: begin
                if (s_q.cnt == '0) begin
                    s_d.retry_flag = 1'b1; // [R11]
                    s_d.st = ST_IDLE;
                end else begin
                    s_d.cnt = s_q.cnt - `CNT_W'(1);
                end
            end
            default: begin
                s_d.st = ST_IDLE;
            end
        endcase
        // set wins over the clear taken in the transfer state
        if (trap_rise || sw_force) begin
            s_d.force_pend = 1'b1; // [R6]
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            s_q <= '{st: ST_IDLE, cnt: '0, membuf: `PSW_RESET, protect: `PSW_RESET,
                     force_pend: 1'b0, trap_prev: 1'b0, retry_flag: 1'b0, ack: 1'b0,
                     rdata: 32'h0000_0000, fetches: 16'h0000};
        end else begin
            s_q <= s_d;
        end
    end

    // whole stall window counts as the difference [R7]
    assign volume_difference        = s_q.st != ST_IDLE;
    assign arithmetic_core_inhibit  = volume_difference; // [R7]
    assign sequence_state_hold_high = volume_difference; // [R7]
    assign sequence_state_hold_low  = !volume_difference;
    assign retry_pulse              = (s_q.st == ST_HOLD) && (s_q.cnt == '0); // [R11]

    // protect word block lives at octal 100..177 [R9]
    assign mem_read_req = s_q.st == ST_FETCH;
    assign mem_addr     = {8'h00, 1'b1, vif.volume};
    assign load_protect_reg = s_q.st == ST_XFER; // [R10]
    assign protect_word = s_q.protect;

    // one wait state: answer on the second edge of the request
    assign avs_waitrequest = bus_req && !s_q.ack;
    assign avs_readdata    = s_q.ack ? s_q.rdata : 32'h0000_0000;

    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);

    sequence fetch_done_s;
        (s_q.st == ST_FETCH) && mem_release;
    endsequence

    sequence xfer_s;
        load_protect_reg ##1 (protect_word == $past(s_q.membuf));
    endsequence

    a_no_trap_idle: assert property ( // [R3]
        (s_q.st == ST_IDLE) && !trapping_mode_ff |=> s_q.st == ST_IDLE)
        else $error("difference started outside trapping mode");

    a_state1_start: assert property ( // [R4]
        (s_q.st == ST_IDLE) && mem_access && trapping_mode_ff && qual_state1 && vif.differ
        |=> volume_difference)
        else $error("state-1 block change not caught");

    a_ireg_start: assert property ( // [R5]
        (s_q.st == ST_IDLE) && mem_access && trapping_mode_ff && qual_ireg && vif.differ
        |=> volume_difference)
        else $error("I-register block change not caught");

    a_force_after_set: assert property ( // [R6]
        trap_rise |=> s_q.force_pend)
        else $error("trapping mode set without forced fetch");

    a_inhibit_busy: assert property ( // [R7]
        volume_difference |-> arithmetic_core_inhibit && sequence_state_hold_high
                              && !sequence_state_hold_low)
        else $error("core not held during difference");

    a_fetch_addr: assert property ( // [R9]
        mem_read_req |-> mem_addr[`PSW_BLOCK_BIT] && mem_addr[`ADDR_W-1:7] == '0
                         && mem_addr[5:0] == vif.volume)
        else $error("protect word address malformed");

    a_word_path: assert property ( // [R10]
        fetch_done_s |=> xfer_s)
        else $error("fetched word not passed to protect register");

    a_hold_word: assert property ( // [R11]
        load_protect_reg |-> ##(1) (volume_difference && s_q.st == ST_HOLD) [*1] ##0
        (s_q.cnt == HOLD_LAST))
        else $error("hold count not started at one word time");

    a_retry_end: assert property ( // [R11]
        retry_pulse |=> !volume_difference && s_q.retry_flag)
        else $error("retry not released after hold");

endmodule

// >>> core_mem_model.sv
// core memory stand-in: releases the stalled access, then serves one protect word
`timescale 1ns/1ps

module core_mem_model (
    // clock and reset
    input  wire logic        clk,
    input  wire logic        srst,
    // answer delay in cycles, set by the bench
    input  wire logic [3:0]  dly,
    // memory side of the block
    input  wire logic        volume_difference,
    input  wire logic        mem_read_req,
    input  wire logic [14:0] mem_addr,
    output logic             mem_release,
    output logic [15:0]      mem_rdata
);
    logic [3:0] cnt;
    logic       done_q;

    always_ff @(posedge clk) begin
        mem_release <= 1'b0;
        // data lines invert every cycle outside reset and a read release, so no word stays steady outside reset or a release
        mem_rdata   <= ~mem_rdata;
        if (srst || !volume_difference) begin
            cnt    <= 4'h0;
            done_q <= 1'b0;
            if (srst)
                mem_rdata <= 16'h0000;
        end else if (mem_release) begin
            cnt <= 4'h0;
        end else if (!done_q || mem_read_req) begin
            if (cnt == dly) begin
                mem_release <= 1'b1;
                cnt         <= 4'h0;
                done_q      <= 1'b1;
                if (mem_read_req)
                    mem_rdata <= 16'ha500 | {9'h000, mem_addr[6:0]};
            end else begin
                cnt <= cnt + 4'h1;
            end
        end
    end
endmodule

// >>> protect_fetch_test.sv
// self-checking bench for the protect word fetch sequencer
`timescale 1ns/1ps
`include "protect_fetch_consts.svh"

module protect_fetch_test;
    logic        clk, srst, avs_read, avs_write, avs_waitrequest, mem_access, trapping_mode_ff;
    logic [4:0]  avs_address;
    logic [31:0] avs_writedata, avs_readdata, rd;
    logic [14:0] address_gate, mem_addr, seen_addr;
    logic [7:0]  q;
    logic        addr_from_p, addr_from_i, state_one, auto_program_interrupt, trap_error;
    logic        execute_indirect_instr, in_quasi, relative_addr, volume_difference;
    logic        arithmetic_core_inhibit, sequence_state_hold_high, sequence_state_hold_low;
    logic        retry_pulse, mem_read_req, mem_release, load_protect_reg;
    logic [15:0] mem_rdata, protect_word;
    logic [3:0]  dly;
    int          n_errors, total_checks, n_fetch, since_load;
    int          n_load = 0;

    // short hold keeps the run brief; the check below follows it
    localparam int HOLD = 2;

    protect_fetch #(.HOLD_CYCLES(HOLD)) uut (.clk(clk), .srst(srst), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .mem_access(mem_access),
        .address_gate(address_gate), .addr_from_p(addr_from_p), .addr_from_i(addr_from_i),
        .state_one(state_one), .auto_program_interrupt(auto_program_interrupt),
        .trap_error(trap_error), .execute_indirect_instr(execute_indirect_instr),
        .in_quasi(in_quasi), .relative_addr(relative_addr), .trapping_mode_ff(trapping_mode_ff),
        .volume_difference(volume_difference), .arithmetic_core_inhibit(arithmetic_core_inhibit),
        .sequence_state_hold_high(sequence_state_hold_high),
        .sequence_state_hold_low(sequence_state_hold_low), .retry_pulse(retry_pulse),
        .mem_addr(mem_addr), .mem_read_req(mem_read_req), .mem_release(mem_release),
        .mem_rdata(mem_rdata), .protect_word(protect_word), .load_protect_reg(load_protect_reg));

    core_mem_model mem (.clk(clk), .srst(srst), .dly(dly), .volume_difference(volume_difference),
        .mem_read_req(mem_read_req), .mem_addr(mem_addr), .mem_release(mem_release),
        .mem_rdata(mem_rdata));

    assign {addr_from_p, addr_from_i, state_one, auto_program_interrupt, trap_error,
            execute_indirect_instr, in_quasi, relative_addr} = q;

    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    always @(posedge clk) begin
        if (mem_read_req === 1'b1 && mem_release === 1'b1)
            seen_addr <= mem_addr;
        if (load_protect_reg === 1'b1)
            n_load <= n_load + 1;
        since_load <= (load_protect_reg === 1'b1) ? 0 : since_load + 1;
    end

    task automatic final_report();
        $display("checks %0d errors %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    task automatic chk_word(input string what, input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("unexpected %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic chk_bit(input string what, input logic exp, input logic got);
        chk_word(what, {31'h0, exp}, {31'h0, got});
    endtask

    // one avalon transfer, held until waitrequest is seen low at a rising edge
    task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] wd);
        int n;
        @(posedge clk);
        avs_address   <= a;
        avs_write     <= wr;
        avs_read      <= ~wr;
        avs_writedata <= wd;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 50);
        if (avs_waitrequest !== 1'b0) begin
            n_errors++;
            final_report();
        end
        // data taken at the same edge that sees waitrequest low
        rd = avs_readdata;
        avs_read  <= 1'b0;
        avs_write <= 1'b0;
    endtask

    // one processor access; a fetch is followed through to its retry
    task automatic access(input logic [14:0] a, input logic [7:0] qual, input logic exp_vd);
        int n;
        int nl;
        nl = n_load;
        @(posedge clk);
        mem_access   <= 1'b1;
        address_gate <= a;
        q            <= qual;
        @(posedge clk);
        mem_access <= 1'b0;
        @(negedge clk);
        chk_bit("volume_difference", exp_vd, volume_difference);
        if (exp_vd) begin
            n_fetch++;
            chk_bit("arithmetic_core_inhibit", 1'b1, arithmetic_core_inhibit);
            chk_bit("sequence_state_hold_high", 1'b1, sequence_state_hold_high);
            chk_bit("sequence_state_hold_low", 1'b0, sequence_state_hold_low);
            n = 0;
            while (retry_pulse !== 1'b1 && n < 300) begin
                @(negedge clk);
                n++;
            end
            if (n >= 300) begin
                n_errors++;
                final_report();
            end
            chk_word("fetch address", {17'h0, 8'h00, 1'b1, a[14:9]}, {17'h0, seen_addr});
            chk_word("protect_word", {16'h0, 16'ha540 | a[14:9]}, {16'h0, protect_word});
            chk_word("load pulses", 1, n_load - nl);
            chk_word("hold cycles", HOLD - 1, since_load);
            @(negedge clk);
            chk_bit("volume_difference", 1'b0, volume_difference);
        end
    endtask

    initial begin
        srst = 1'b1; avs_read = 1'b0; avs_write = 1'b0; avs_address = 5'h00;
        avs_writedata = 32'h0; mem_access = 1'b0; address_gate = 15'h0000; q = 8'h00;
        trapping_mode_ff = 1'b0; dly = 4'h0;
        n_errors = 0; total_checks = 0; n_fetch = 0;
        repeat (20) @(posedge clk);
        srst <= 1'b0;
        bus(1'b0, `OFS_STATUS, 32'h0);
        chk_word("status", 32'h0, rd);
        bus(1'b0, 5'h10, 32'h0);
        chk_word("unmapped", 32'h0, rd);
        access(15'h0200, 8'ha0, 1'b0);
        @(posedge clk) trapping_mode_ff <= 1'b1;
        repeat (2) @(posedge clk);
        access(15'h0000, 8'ha0, 1'b1);
        access(15'h0000, 8'ha0, 1'b0);
        access(15'h0005, 8'ha0, 1'b0);
        dly <= 4'h5;
        access(15'h0200, 8'ha0, 1'b1);
        access(15'h0200, 8'ha0, 1'b0);
        bus(1'b0, `OFS_STATUS, 32'h0);
        chk_word("status", 32'h0000_0201, rd);
        for (int k = 1; k <= 4; k++) begin
            access(15'h7e00, 8'ha0 | (8'h01 << k), 1'b0);
        end
        access(15'h4400, 8'h40, 1'b1);
        access(15'h4400, 8'h40, 1'b0);
        access(15'h1000, 8'h43, 1'b0);
        access(15'h1000, 8'h50, 1'b0);
        access(15'h1000, 8'h48, 1'b0);
        dly <= 4'h0;
        access(15'h1000, 8'h42, 1'b1);
        access(15'h1000, 8'h42, 1'b0);
        bus(1'b1, `OFS_CTRL, 32'h1);
        bus(1'b0, `OFS_STATUS, 32'h0);
        chk_word("status", 32'h0000_0608, rd);
        access(15'h1000, 8'ha0, 1'b1);
        bus(1'b0, `OFS_FETCHES, 32'h0);
        chk_word("fetches", n_fetch, rd);
        bus(1'b0, `OFS_PROTECT, 32'h0);
        chk_word("protect", 32'h0000_a548, rd);
        final_report();
    end
endmodule
